// >>> hw/reset_init_sequencer.sv
// Reset initialization sequencer: orders hard/soft reset and straps
`timescale 1ns/1ns
module reset_init_sequencer
	import reset_seq_pkg::*;
#(
	parameter int PLL_LOCK_CYCLES = reset_seq_pkg::PLL_LOCK_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic host_mode_in,
	input wire logic power_on_reset_n_in,
	input wire logic hard_reset_n_in,
	input wire logic soft_reset_n_in,
	input wire logic [reset_seq_pkg::RST_SRC_W-1:0] reset_source_strap_in,
	input wire logic clock_divide_strap_in,
	output logic [reset_seq_pkg::RST_SRC_W-1:0] reset_source_strap_out,
	output logic clock_divide_strap_out,
	output logic strap_oe_out,
	output logic hard_reset_n_out,
	output logic hard_reset_oe_out,
	output logic soft_reset_n_out,
	output logic soft_reset_oe_out,
	output logic pll_locked_out,
	output logic reset_done_out
);
	import reset_seq_pkg::*;

	reset_req_if req ();

	// Reset input synchronizer and length filter
	reset_input_filter u_filter (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.power_on_reset_n_in(power_on_reset_n_in),
		.hard_reset_n_in(hard_reset_n_in),
		.soft_reset_n_in(soft_reset_n_in),
		.req(req.filt)
	);

	localparam logic [CNT_W-1:0] ASSERT_LAST = CNT_W'(OUT_ASSERT_TICKS - 1);
	localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(SOFT_GAP_TICKS - 1);
	// One tick more: the first period after entry may be partial
	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(OUT_ASSERT_TICKS);
	localparam logic [CNT_W-1:0] PLL_LAST = CNT_W'(PLL_LOCK_CYCLES - 1);

	seq_state_t state_reg, state_next; // Sequencer state
	logic [CNT_W-1:0] cnt_reg, cnt_next; // Cycles or sync periods
	logic div_reg, div_next; // Half-rate phase for tick
	logic tick_reg, tick_next; // One pulse per sync period
	logic [RST_SRC_W-1:0] src_reg, src_next; // Captured reset source
	logic cdiv_reg, cdiv_next; // Captured clock divide select
	logic strap_oe_reg, strap_oe_next;
	logic hard_n_reg, hard_n_next;
	logic soft_n_reg, soft_n_next;
	logic hard_oe_reg, hard_oe_next; // Drives the hard pin while low
	logic soft_oe_reg, soft_oe_next; // Drives the soft pin while low
	logic pll_reg, pll_next;
	logic done_reg, done_next;

	// Sync period tick; agent mode clk_in already is the sync clock
	always_comb begin
		div_next = !div_reg;
		if (host_mode_in && cdiv_reg) begin
			tick_next = div_reg;
		end else begin
			tick_next = 1'b1;
			div_next = 1'b0;
		end
	end
	assign req.tick = tick_reg;

	// Sequencer next state; power-on overrides all but the captured straps and the tick divider
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		src_next = src_reg;
		cdiv_next = cdiv_reg;
		strap_oe_next = strap_oe_reg;
		hard_n_next = hard_n_reg;
		soft_n_next = soft_n_reg;
		pll_next = pll_reg;
		done_next = 1'b0;
		case (state_reg)
			// Held while power-on reset stands
			ST_POR: begin
				if (req.por_release) begin
					// Straps were set up well before this edge
					src_next = reset_source_strap_in;
					cdiv_next = clock_divide_strap_in;
					state_next = ST_PLL;
					cnt_next = '0;
				end
			end
			// Counts raw cycles: PLL bound is absolute time
			ST_PLL: begin
				if (cnt_reg == PLL_LAST) begin
					pll_next = 1'b1;
					state_next = ST_HARD;
					cnt_next = '0;
				end else begin
					cnt_next = cnt_reg + 16'h0001;
				end
			end
			// Both outputs low for the full count
			ST_HARD: begin
				if (tick_reg) begin
					if (cnt_reg == HOLD_LAST) begin
						hard_n_next = 1'b1;
						state_next = ST_GAP;
						cnt_next = '0;
					end else begin
						cnt_next = cnt_reg + 16'h0001;
					end
				end
			end
			// Hard released; soft still held
			ST_GAP: begin
				if (req.hard_req) begin
					state_next = ST_HARD;
					cnt_next = '0;
					hard_n_next = 1'b0;
					strap_oe_next = 1'b0;
				end else if (tick_reg) begin
					strap_oe_next = 1'b1;
					if (cnt_reg == GAP_LAST) begin
						soft_n_next = 1'b1;
						state_next = ST_RUN;
						done_next = 1'b1;
					end else begin
						cnt_next = cnt_reg + 16'h0001;
					end
				end
			end
			// Soft-only flow from the soft input
			ST_SOFT: begin
				if (req.hard_req) begin
					state_next = ST_HARD;
					cnt_next = '0;
					hard_n_next = 1'b0;
					strap_oe_next = 1'b0;
				end else if (tick_reg) begin
					if (cnt_reg == HOLD_LAST) begin
						soft_n_next = 1'b1;
						state_next = ST_RUN;
						done_next = 1'b1;
					end else begin
						cnt_next = cnt_reg + 16'h0001;
					end
				end
			end
			// Running; hard request wins over soft
			ST_RUN: begin
				if (req.hard_req) begin
					state_next = ST_HARD;
					cnt_next = '0;
					hard_n_next = 1'b0;
					soft_n_next = 1'b0;
					// Same edge as hard assertion, inside the 4 ns bound
					strap_oe_next = 1'b0;
				end else if (req.soft_req) begin
					state_next = ST_SOFT;
					cnt_next = '0;
					soft_n_next = 1'b0;
				end
			end
			default: begin
				state_next = ST_POR;
			end
		endcase
		// Power-on asserted: sequence and outputs back to the start; captured straps and tick divider kept
		if (req.por_active) begin
			state_next = ST_POR;
			cnt_next = '0;
			hard_n_next = 1'b0;
			soft_n_next = 1'b0;
			strap_oe_next = 1'b0;
			pll_next = 1'b0;
			done_next = 1'b0;
		end
		// Enables registered too, so every pin comes from a flip-flop
		hard_oe_next = !hard_n_next;
		soft_oe_next = !soft_n_next;
	end

	// Registers; reset state drives both resets low, straps released
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= ST_POR;
			cnt_reg <= '0;
			div_reg <= 1'b0;
			tick_reg <= 1'b0;
			src_reg <= RST_SRC_RESET;
			cdiv_reg <= DIV_STRAP_RESET;
			strap_oe_reg <= 1'b0;
			hard_n_reg <= 1'b0;
			soft_n_reg <= 1'b0;
			hard_oe_reg <= 1'b1;
			soft_oe_reg <= 1'b1;
			pll_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			div_reg <= div_next;
			tick_reg <= tick_next;
			src_reg <= src_next;
			cdiv_reg <= cdiv_next;
			strap_oe_reg <= strap_oe_next;
			hard_n_reg <= hard_n_next;
			soft_n_reg <= soft_n_next;
			hard_oe_reg <= hard_oe_next;
			soft_oe_reg <= soft_oe_next;
			pll_reg <= pll_next;
			done_reg <= done_next;
		end
	end

	// Outputs, all straight from flip-flops
	assign reset_source_strap_out = src_reg;
	assign clock_divide_strap_out = cdiv_reg;
	assign strap_oe_out = strap_oe_reg;
	assign hard_reset_n_out = hard_n_reg;
	assign hard_reset_oe_out = hard_oe_reg;
	assign soft_reset_n_out = soft_n_reg;
	assign soft_reset_oe_out = soft_oe_reg;
	assign pll_locked_out = pll_reg;
	assign reset_done_out = done_reg;

	// Helper: sync periods while asserted, and since hard negation
	logic [CNT_W-1:0] hard_low_ticks, soft_low_ticks, since_hard_ticks;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hard_low_ticks <= '0;
			soft_low_ticks <= '0;
			since_hard_ticks <= '0;
		end else begin
			hard_low_ticks <= hard_n_reg ? '0 : hard_low_ticks + 16'(tick_reg);
			soft_low_ticks <= soft_n_reg ? '0 : soft_low_ticks + 16'(tick_reg);
			since_hard_ticks <= !hard_n_reg ? '0 :
				since_hard_ticks + 16'(tick_reg);
		end
	end

	AST_HARD_WIDTH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(hard_n_reg) |-> $past(hard_low_ticks) >= ASSERT_LAST)
		else $error("hard reset output too short");
	AST_SOFT_WIDTH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(soft_n_reg) && !$past(req.por_active)
		|-> $past(soft_low_ticks) >= ASSERT_LAST)
		else $error("soft reset output too short");
	AST_SOFT_GAP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(soft_n_reg) && $past(state_reg) == ST_GAP
		|-> $past(since_hard_ticks) >= GAP_LAST)
		else $error("soft negated too soon after hard");
	AST_STRAP_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!hard_n_reg |-> !strap_oe_reg)
		else $error("straps driven during hard reset");
	AST_STRAP_ON: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(strap_oe_reg) |-> hard_n_reg && $past(hard_n_reg)
		&& $past(tick_reg))
		else $error("straps driven too soon after hard");
	AST_STRAP_CAPTURE: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		state_reg == ST_POR && req.por_release && !req.por_active
		|=> src_reg == $past(reset_source_strap_in)
		&& cdiv_reg == $past(clock_divide_strap_in))
		else $error("straps not sampled at power-on release");
	AST_PLL_WAIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(hard_n_reg) |-> pll_reg)
		else $error("left reset before PLL bound");
	AST_TICK_HALF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		host_mode_in && cdiv_reg && $past(host_mode_in && cdiv_reg)
		&& tick_reg |=> !tick_reg)
		else $error("sync tick not divided in host mode");
endmodule

// >>> hw/reset_input_filter.sv
// Synchronizes reset inputs and measures hard and soft assertion length
`timescale 1ns/1ns
module reset_input_filter
	import reset_seq_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic power_on_reset_n_in,
	input wire logic hard_reset_n_in,
	input wire logic soft_reset_n_in,
	reset_req_if.filt req
);
	import reset_seq_pkg::*;

	logic [2:0] meta_reg, meta_next; // First stage, read by second only
	logic [2:0] sync_reg, sync_next; // Second stage: {por, hard, soft}
	logic [IN_CNT_W-1:0] hard_cnt_reg, hard_cnt_next;
	logic [IN_CNT_W-1:0] soft_cnt_reg, soft_cnt_next;
	logic hard_req_reg, hard_req_next;
	logic soft_req_reg, soft_req_next;
	logic por_act_reg, por_act_next;
	logic por_rel_reg, por_rel_next;

	localparam logic [IN_CNT_W-1:0] IN_LAST = IN_CNT_W'(IN_MIN_TICKS - 1);

	// Next values: a glitch shorter than the minimum restarts the count
	always_comb begin
		meta_next = {power_on_reset_n_in, hard_reset_n_in, soft_reset_n_in};
		sync_next = meta_reg;
		hard_cnt_next = hard_cnt_reg;
		soft_cnt_next = soft_cnt_reg;
		hard_req_next = 1'b0;
		soft_req_next = 1'b0;
		// Hard input assertion length, counted in sync periods
		if (sync_reg[1]) begin
			hard_cnt_next = '0;
		end else if (req.tick && hard_cnt_reg != IN_LAST + 6'h01) begin
			hard_cnt_next = hard_cnt_reg + 6'h01;
			hard_req_next = (hard_cnt_reg == IN_LAST);
		end
		// Soft input, same measure
		if (sync_reg[0]) begin
			soft_cnt_next = '0;
		end else if (req.tick && soft_cnt_reg != IN_LAST + 6'h01) begin
			soft_cnt_next = soft_cnt_reg + 6'h01;
			soft_req_next = (soft_cnt_reg == IN_LAST);
		end
		// Power-on level and its release edge
		por_act_next = !sync_reg[2];
		por_rel_next = por_act_reg && sync_reg[2];
	end

	// Registers; synchronizer starts as if inputs were asserted
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_reg <= 3'h0;
			sync_reg <= 3'h0;
			hard_cnt_reg <= '0;
			soft_cnt_reg <= '0;
			hard_req_reg <= 1'b0;
			soft_req_reg <= 1'b0;
			por_act_reg <= 1'b1;
			por_rel_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			hard_cnt_reg <= hard_cnt_next;
			soft_cnt_reg <= soft_cnt_next;
			hard_req_reg <= hard_req_next;
			soft_req_reg <= soft_req_next;
			por_act_reg <= por_act_next;
			por_rel_reg <= por_rel_next;
		end
	end

	assign req.hard_req = hard_req_reg;
	assign req.soft_req = soft_req_reg;
	assign req.por_active = por_act_reg;
	assign req.por_release = por_rel_reg;

	// A request only after the full count of low periods
	AST_HARD_REQ_LEN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		hard_req_reg |-> $past(hard_cnt_reg) == IN_LAST && !$past(sync_reg[1]))
		else $error("hard request before minimum assertion");
	// A one-cycle high blip clears the measured length
	AST_GLITCH_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sync_reg[0] |=> soft_cnt_reg == '0)
		else $error("soft count kept across a glitch");
endmodule

// >>> hw/reset_req_if.sv
// Carrier between the sequencer and its reset input filter
`timescale 1ns/1ns
interface reset_req_if;
	logic tick; // One cycle per sync clock period
	logic hard_req; // Pulse: hard input held long enough
	logic soft_req; // Pulse: soft input held long enough
	logic por_active; // Level: synchronized power-on reset asserted
	logic por_release; // Pulse: power-on reset just negated

	modport filt (
		input tick,
		output hard_req,
		output soft_req,
		output por_active,
		output por_release
	);
	modport seq (
		output tick,
		input hard_req,
		input soft_req,
		input por_active,
		input por_release
	);
endinterface

// >>> hw/reset_seq_pkg.sv
// Shared constants and types for the reset initialization sequencer
package reset_seq_pkg;
	// Clock rate of clk_in
	localparam int CLK_MHZ = 100;
	localparam int CLK_PERIOD_NS = 10;
	// Least assertion of a reset input, in sync periods
	localparam int IN_MIN_TICKS = 32;
	// Least assertion of the hard and soft reset outputs, in sync periods
	localparam int OUT_ASSERT_TICKS = 512;
	// Least gap from hard negation to soft negation, in sync periods
	localparam int SOFT_GAP_TICKS = 16;
	// Least delay before straps are driven again, in sync periods
	localparam int STRAP_ON_TICKS = 1;
	// Longest time to release the strap pins after hard assertion
	localparam int STRAP_OFF_NS = 4;
	// Rounded down, but never below one cycle
	localparam int STRAP_OFF_CYC = (STRAP_OFF_NS / CLK_PERIOD_NS) < 1 ?
		1 : (STRAP_OFF_NS / CLK_PERIOD_NS);
	// PLL lock bound after the clock is stable
	localparam int PLL_LOCK_US = 100;
	localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
	// Counter widths
	localparam int CNT_W = 16;
	localparam int IN_CNT_W = 6;
	// Strap field widths
	localparam int RST_SRC_W = 3;
	// Reset values
	localparam logic [RST_SRC_W-1:0] RST_SRC_RESET = 3'h0;
	localparam logic DIV_STRAP_RESET = 1'h0;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_POR = 3'b000,
		ST_PLL = 3'b001,
		ST_HARD = 3'b010,
		ST_GAP = 3'b011,
		ST_SOFT = 3'b100,
		ST_RUN = 3'b101
	} seq_state_t;
endpackage

// >>> test/board_reset_model.sv
// Board-side model: power-on, hard and soft reset drivers and strap drivers
`timescale 1ns/1ns
module board_reset_model (
	input wire logic clk_in,
	output logic power_on_reset_n_out,
	output logic hard_reset_n_out,
	output logic soft_reset_n_out,
	output logic [2:0] strap_src_out,
	output logic strap_div_out,
	output logic strap_drive_out
);
	int hold_cnt = 9; // Cycles since power-on negation, saturating
	logic por_seen; // Power-on level just before the edge

	// Idle board: no reset asserted, straps not driven
	initial begin
		power_on_reset_n_out = 1'b1;
		hard_reset_n_out = 1'b1;
		soft_reset_n_out = 1'b1;
		strap_src_out = 3'h0;
		strap_div_out = 1'h0;
	end

	// Board keeps straps up through power-on and 8 cycles past it
	always @(posedge clk_in) begin
		por_seen = power_on_reset_n_out;
		#1;
		if (!por_seen) begin
			hold_cnt = 0;
		end else if (hold_cnt < 9) begin
			hold_cnt = hold_cnt + 1;
		end
		strap_drive_out = (hold_cnt < 9);
	end

	// Power-on pulse with straps set up from its start
	task automatic power_on(input logic [2:0] src, input logic div,
		input int hold);
		@(posedge clk_in);
		#1;
		power_on_reset_n_out = 1'b0;
		strap_src_out = src;
		strap_div_out = div;
		// Hold is at least 32 cycles of the clock in use
		repeat (hold) @(posedge clk_in);
		#1;
		power_on_reset_n_out = 1'b1;
	endtask

	// Level changes on the hard reset pin; holding time is the caller's
	task automatic set_hard(input logic v);
		@(posedge clk_in);
		#1;
		hard_reset_n_out = v;
	endtask

	// Level changes on the soft reset pin
	task automatic set_soft(input logic v);
		@(posedge clk_in);
		#1;
		soft_reset_n_out = v;
	endtask
endmodule

// >>> test/tb_reset_init_sequencer.sv
// Self-checking testbench for the reset initialization sequencer
`timescale 1ns/1ns
module tb_reset_init_sequencer;
	import reset_seq_pkg::*;
	localparam int PLL_CYC = 20;
	logic clk_in = 1'b0; // 100 MHz clock
	logic rst_n_in = 1'b0; // Async reset, active low
	logic host_mode = 1'b0; // Role select
	logic por_n, hard_n, soft_n, div_m, drive_m;
	logic [2:0] src_m;
	logic [RST_SRC_W-1:0] src_pin, src_out;
	logic div_pin, div_out, strap_oe, hard_out, hard_oe;
	logic soft_out, soft_oe, pll_locked, done;
	int n_fail = 0;
	int checks_done = 0;

	// Clock
	always #5 clk_in = ~clk_in;

	// Strap wire: device, board, or drifting level when nobody drives
	assign src_pin = strap_oe ? src_out : (drive_m ? src_m : ~src_m);
	assign div_pin = strap_oe ? div_out : (drive_m ? div_m : ~div_m);

	board_reset_model i_board_reset_model (
		.clk_in(clk_in), .power_on_reset_n_out(por_n),
		.hard_reset_n_out(hard_n), .soft_reset_n_out(soft_n),
		.strap_src_out(src_m), .strap_div_out(div_m),
		.strap_drive_out(drive_m)
	);

	reset_init_sequencer #(.PLL_LOCK_CYCLES(PLL_CYC)) i_reset_init_sequencer (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .host_mode_in(host_mode),
		.power_on_reset_n_in(por_n), .hard_reset_n_in(hard_n),
		.soft_reset_n_in(soft_n), .reset_source_strap_in(src_pin),
		.clock_divide_strap_in(div_pin),
		.reset_source_strap_out(src_out), .clock_divide_strap_out(div_out),
		.strap_oe_out(strap_oe), .hard_reset_n_out(hard_out),
		.hard_reset_oe_out(hard_oe), .soft_reset_n_out(soft_out),
		.soft_reset_oe_out(soft_oe), .pll_locked_out(pll_locked),
		.reset_done_out(done)
	);

	// Single comparison point
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// One cycle, sampled after the edge has settled
	task automatic step();
		@(posedge clk_in);
		#2;
	endtask

	// Measures a running hard/soft sequence from the current cycle
	task automatic measure_seq(input int hmin, input int gmin);
		int n;
		int g;
		int s;
		logic bad;
		n = 0;
		bad = 1'b0;
		while (hard_out === 1'b0 && n < 3000) begin
			bad = bad | (strap_oe !== 1'b0) | (hard_oe !== 1'b1);
			step();
			n++;
		end
		check("hard_len", n >= hmin && n < 3000, 1'b1);
		check("strap_off_in_hard", bad, 1'b0);
		g = 0;
		s = 0;
		while (soft_out === 1'b0 && g < 3000) begin
			if (strap_oe !== 1'b1) s++;
			step();
			g++;
		end
		check("soft_gap", g >= gmin && g < 3000, 1'b1);
		check("strap_on_delay", s >= 1, 1'b1);
		check("done_pulse", done, 1'b1);
		step();
		check("done_clear", done, 1'b0);
	endtask

	// Power-on flow, then PLL wait and the full output sequence
	task automatic t_power_on(input logic host, input logic [2:0] src,
		input logic div, input int hmin, input int gmin);
		int c;
		@(posedge clk_in);
		#1;
		host_mode = host;
		i_board_reset_model.power_on(src, div, 32);
		c = 0;
		while (pll_locked !== 1'b1 && c < 500) begin
			step();
			c++;
		end
		check("pll_wait", c >= PLL_CYC && c < 500, 1'b1);
		check("pll_set", pll_locked, 1'b1);
		check("hard_held", hard_out, 1'b0);
		measure_seq(hmin, gmin);
		check("src_capture", src_out, src);
		check("div_capture", div_out, div);
		check("strap_drive", strap_oe, 1'b1);
		$display("test power_on host=%0d done", host);
	endtask

	// Short glitch ignored, then a full hard request runs the sequence
	task automatic t_hard_input();
		int c;
		logic low_seen;
		@(posedge clk_in);
		#1;
		host_mode = 1'b0;
		i_board_reset_model.set_hard(1'b0);
		repeat (20) step();
		i_board_reset_model.set_hard(1'b1);
		low_seen = 1'b0;
		repeat (60) begin
			step();
			low_seen = low_seen | (hard_out !== 1'b1);
		end
		check("glitch_ignored", low_seen, 1'b0);
		i_board_reset_model.set_hard(1'b0);
		c = 0;
		while (hard_out !== 1'b0 && c < 100) begin
			step();
			c++;
		end
		check("hard_taken", c >= 32 && c < 100, 1'b1);
		check("strap_release", strap_oe, 1'b0);
		check("soft_with_hard", soft_out, 1'b0);
		i_board_reset_model.set_hard(1'b1);
		measure_seq(OUT_ASSERT_TICKS, SOFT_GAP_TICKS);
		$display("test hard_input done");
	endtask

	// Soft request drives soft reset only
	task automatic t_soft_input();
		int c;
		i_board_reset_model.set_soft(1'b0);
		c = 0;
		while (soft_out !== 1'b0 && c < 100) begin
			step();
			c++;
		end
		check("soft_taken", c >= 32 && c < 100, 1'b1);
		check("hard_untouched", hard_out, 1'b1);
		check("soft_oe", soft_oe, 1'b1);
		i_board_reset_model.set_soft(1'b1);
		c = 0;
		while (soft_out === 1'b0 && c < 3000) begin
			step();
			c++;
		end
		check("soft_len", c >= OUT_ASSERT_TICKS && c < 3000, 1'b1);
		$display("test soft_input done");
	endtask

	// Reset in mid-run: reset values at once, held past release
	task automatic t_mid_reset();
		@(posedge clk_in);
		#1;
		rst_n_in = 1'b0;
		#1;
		check("rst_hard", hard_out, 1'b0);
		check("rst_hard_oe", hard_oe, 1'b1);
		check("rst_soft", soft_out, 1'b0);
		check("rst_soft_oe", soft_oe, 1'b1);
		check("rst_strap_oe", strap_oe, 1'b0);
		check("rst_src", src_out, RST_SRC_RESET);
		check("rst_pll", pll_locked, 1'b0);
		check("rst_done", done, 1'b0);
		repeat (2) step();
		@(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		// First two edges: power-on hold still stands
		repeat (2) begin
			step();
			check("rel_hard", hard_out, 1'b0);
			check("rel_strap_oe", strap_oe, 1'b0);
			check("rel_pll", pll_locked, 1'b0);
		end
		$display("test mid_reset done");
	endtask

	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		step();
		t_power_on(1'b0, 3'h5, 1'b0, OUT_ASSERT_TICKS, SOFT_GAP_TICKS);
		t_power_on(1'b1, 3'h2, 1'b1, 2 * OUT_ASSERT_TICKS,
			2 * SOFT_GAP_TICKS);
		t_power_on(1'b1, 3'h6, 1'b0, OUT_ASSERT_TICKS, SOFT_GAP_TICKS);
		t_hard_input();
		t_soft_input();
		t_mid_reset();
		t_power_on(1'b0, 3'h3, 1'b0, OUT_ASSERT_TICKS, SOFT_GAP_TICKS);
		final_report();
	end

	// Watchdog well beyond the expected few thousand cycles
	initial begin
		#200000;
		n_fail++;
		$display("MISMATCH watchdog expected finish seen timeout");
		final_report();
	end
endmodule
